// ==== pwm_duty_phase_deadtime_regs.v ====
// Duty, phase and dead-time registers of one PWM generator, with the
// output shaping that they steer.
// Assumes a simple register port: one-cycle strobes, read data valid
// in the cycle after the read strobe; everything on core_clk_i.
`timescale 1ns/10ps
`include "pwm_timing_defines.vh"

module pwm_duty_phase_deadtime_regs #(
  parameter WIDTH    = 16,
  parameter DT_WIDTH = `DT_WIDTH
) (
  input  wire             core_clk_i,
  input  wire             rst_i,
  input  wire             clk_en_i,
  input  wire [3:0]       addr_i,
  input  wire [15:0]      wdata_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output reg  [15:0]      rdata_o,
  output reg              high_side_out_o,
  output reg              low_side_out_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [WIDTH-1:0] clamp;
    input [WIDTH-1:0] v;
    input [WIDTH-1:0] lo;
    input [WIDTH-1:0] hi;
    begin
      if (v < lo)
        clamp = lo;
      else if (v > hi)
        clamp = hi;
      else
        clamp = v;
    end
  endfunction

  // Phase-shifted count, wrapping modulo period + 1
  function [WIDTH-1:0] shift_count;
    input [WIDTH-1:0] cnt;
    input [WIDTH-1:0] ph;
    input [WIDTH-1:0] per;
    reg   [WIDTH:0]   sum;
    begin
      sum = {1'b0, cnt} + {1'b0, ph};
      if (sum > {1'b0, per})
        sum = sum - {1'b0, per} - {{WIDTH{1'b0}}, 1'b1};
      if (sum > {1'b0, per})
        sum = {1'b0, per};
      shift_count = sum[WIDTH-1:0];
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [WIDTH-1:0]    primary_duty_r;
  reg  [WIDTH-1:0]    secondary_duty_r;
  reg  [WIDTH-1:0]    primary_phase_r;
  reg  [WIDTH-1:0]    secondary_phase_r;
  reg  [DT_WIDTH-1:0] dead_time_r;
  reg  [DT_WIDTH-1:0] alternate_dead_time_r;
  reg                 immediate_update_r;
  reg  [1:0]          dead_time_control_r;
  reg                 time_base_select_r;
  reg  [1:0]          pin_mode_r;
  reg  [WIDTH-1:0]    master_period_r;
  reg  [WIDTH-1:0]    act_pduty_r;
  reg  [WIDTH-1:0]    act_sduty_r;

  wire                wrap_h;
  wire                wrap_l;
  wire                wrap_m;
  wire                independent;

  assign independent = (pin_mode_r == `PIN_MODE_INDEPENDENT);

  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      primary_duty_r        <= `RST_ZERO16;
      secondary_duty_r      <= `RST_ZERO16;
      primary_phase_r       <= `RST_ZERO16;
      secondary_phase_r     <= `RST_ZERO16;
      dead_time_r           <= {DT_WIDTH{1'b0}};
      alternate_dead_time_r <= {DT_WIDTH{1'b0}};
      immediate_update_r    <= 1'b0;
      dead_time_control_r   <= `DTC_POSITIVE;
      time_base_select_r    <= 1'b0;
      pin_mode_r            <= `PIN_MODE_COMPLEMENTARY;
      master_period_r       <= `RST_MASTER_PERIOD;
    end
    else if (clk_en_i && wr_i)
    begin
      case (addr_i)
        `ADDR_PRIMARY_DUTY:
          primary_duty_r <= wdata_i;
        `ADDR_SECONDARY_DUTY:
          secondary_duty_r <= wdata_i;
        `ADDR_PRIMARY_PHASE:
          primary_phase_r <= wdata_i;
        `ADDR_SECONDARY_PHASE:
          secondary_phase_r <= wdata_i;
        `ADDR_DEAD_TIME:
          dead_time_r <= wdata_i[DT_WIDTH-1:0];
        `ADDR_ALTERNATE_DEAD_TIME:
          alternate_dead_time_r <= wdata_i[DT_WIDTH-1:0];
        `ADDR_GENERATOR_CONTROL:
        begin
          immediate_update_r  <= wdata_i[`CTL_IMMEDIATE_UPDATE_BIT];
          dead_time_control_r <= wdata_i[`CTL_DTC_LSB+1:`CTL_DTC_LSB];
          time_base_select_r  <= wdata_i[`CTL_TIME_BASE_SELECT_BIT];
        end
        `ADDR_OUTPUT_PIN_CONTROL:
          pin_mode_r <= wdata_i[`PIN_MODE_LSB+1:`PIN_MODE_LSB];
        `ADDR_MASTER_PERIOD:
          master_period_r <= wdata_i;
        default:
          ;
      endcase
    end
  end

  // ****************************************************************
  // Time bases
  // ****************************************************************
  wire [WIDTH-1:0] cnt_m;
  wire [WIDTH-1:0] cnt_h;
  wire [WIDTH-1:0] cnt_l;
  wire [WIDTH-1:0] per_h;
  wire [WIDTH-1:0] per_l;

  // Own time base: primary phase is the period; in independent mode
  // the low side takes its period from the secondary phase instead.
  assign per_h = time_base_select_r ? primary_phase_r
                                    : master_period_r;
  assign per_l = !time_base_select_r ? master_period_r :
                 independent ? secondary_phase_r
                             : primary_phase_r;

  pwm_time_base #(.WIDTH(WIDTH)) u_tb_master (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .period_i   (master_period_r),
    .count_o    (cnt_m),
    .wrap_o     (wrap_m)
  );

  pwm_time_base #(.WIDTH(WIDTH)) u_tb_high (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .period_i   (per_h),
    .count_o    (cnt_h),
    .wrap_o     (wrap_h)
  );

  pwm_time_base #(.WIDTH(WIDTH)) u_tb_low (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .period_i   (per_l),
    .count_o    (cnt_l),
    .wrap_o     (wrap_l)
  );

  // ****************************************************************
  // Duty buffering
  // ****************************************************************
  // Buffered duty avoids a runt pulse when software writes mid-period
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      act_pduty_r <= `RST_ZERO16;
      act_sduty_r <= `RST_ZERO16;
    end
    else if (clk_en_i)
    begin
      if (immediate_update_r || wrap_h)
        act_pduty_r <= primary_duty_r;
      if (immediate_update_r || wrap_l)
        act_sduty_r <= secondary_duty_r;
    end
  end

  // ****************************************************************
  // Phase and duty selection
  // ****************************************************************
  reg  [WIDTH-1:0] ph_h;
  reg  [WIDTH-1:0] ph_l;
  reg  [WIDTH-1:0] duty_h;
  reg  [WIDTH-1:0] duty_l;
  reg  [WIDTH-1:0] hi_h;
  reg  [WIDTH-1:0] hi_l;
  reg  [WIDTH-1:0] pos_h;
  reg  [WIDTH-1:0] pos_l;

  always @*
  begin
    // Phase shift exists only on the master time base
    ph_h = `RST_ZERO16;
    ph_l = `RST_ZERO16;
    if (!time_base_select_r)
    begin
      if (independent)
      begin
        ph_l = primary_phase_r;
        ph_h = `RST_ZERO16;
      end
      else
      begin
        ph_h = primary_phase_r;
        ph_l = primary_phase_r;
      end
    end
    // Own period leaves a margin at the top; master uses fixed ceiling
    hi_h = time_base_select_r ? per_h - `PERIOD_MARGIN
                              : `DUTY_MAX;
    hi_l = time_base_select_r ? per_l - `PERIOD_MARGIN
                              : `DUTY_MAX;
    duty_h = clamp(act_pduty_r, `DUTY_MIN, hi_h);
    duty_l = independent ? clamp(act_sduty_r, `DUTY_MIN, hi_l)
                         : clamp(act_pduty_r, `DUTY_MIN, hi_l);
    pos_h = shift_count(cnt_h, ph_h, per_h);
    pos_l = independent ? shift_count(cnt_l, ph_l, per_l)
                        : pos_h;
  end

  // ****************************************************************
  // Output shaping and dead time
  // ****************************************************************
  reg              raw_h;
  reg              raw_l;
  reg              prev_raw_r;
  reg [DT_WIDTH-1:0] dt_cnt_r;
  reg              push_sel_r;

  always @*
  begin
    raw_h = (pos_h < duty_h);
    raw_l = (pos_l < duty_l);
  end

  // Dead time: positive delays the rising edge of each side by
  // dead_time (high) or alternate_dead_time (low); negative widens
  // the pulses so they overlap instead. The 40 ns ramp zone is one
  // clock here, so edge pulses simply lose whole clocks.
  wire [DT_WIDTH-1:0] dt_sel;
  assign dt_sel = prev_raw_r ? alternate_dead_time_r : dead_time_r;

  // Blanking starts on the edge itself, so a zero count costs no clock
  wire                dt_busy;
  assign dt_busy = (raw_h != prev_raw_r) ? (dt_sel != {DT_WIDTH{1'b0}})
                                         : (dt_cnt_r != {DT_WIDTH{1'b0}});

  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_raw_r      <= 1'b0;
      dt_cnt_r        <= {DT_WIDTH{1'b0}};
      push_sel_r      <= 1'b0;
      high_side_out_o <= 1'b0;
      low_side_out_o  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      prev_raw_r <= raw_h;
      if (wrap_h)
        push_sel_r <= ~push_sel_r;
      if (raw_h != prev_raw_r)
        dt_cnt_r <= dt_busy ? dt_sel - {{(DT_WIDTH-1){1'b0}}, 1'b1} : dt_sel;
      else if (dt_cnt_r != {DT_WIDTH{1'b0}})
        dt_cnt_r <= dt_cnt_r - {{(DT_WIDTH-1){1'b0}}, 1'b1};
      case (pin_mode_r)
        `PIN_MODE_COMPLEMENTARY:
        begin
          case (dead_time_control_r)
            `DTC_POSITIVE:
            begin
              high_side_out_o <= raw_h && !dt_busy;
              low_side_out_o  <= !raw_h && !dt_busy;
            end
            `DTC_NEGATIVE:
            begin
              high_side_out_o <= raw_h || dt_busy;
              low_side_out_o  <= !raw_h || dt_busy;
            end
            default:
            begin
              high_side_out_o <= raw_h;
              low_side_out_o  <= !raw_h;
            end
          endcase
        end
        `PIN_MODE_REDUNDANT:
        begin
          high_side_out_o <= raw_h;
          low_side_out_o  <= raw_h;
        end
        `PIN_MODE_PUSH_PULL:
        begin
          high_side_out_o <= raw_h && !push_sel_r;
          low_side_out_o  <= raw_h && push_sel_r;
        end
        default:
        begin
          high_side_out_o <= raw_h;
          low_side_out_o  <= raw_l;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (clk_en_i && rd_i)
    begin
      case (addr_i)
        `ADDR_PRIMARY_DUTY:
          rdata_o <= primary_duty_r;
        `ADDR_SECONDARY_DUTY:
          rdata_o <= secondary_duty_r;
        `ADDR_PRIMARY_PHASE:
          rdata_o <= primary_phase_r;
        `ADDR_SECONDARY_PHASE:
          rdata_o <= secondary_phase_r;
        `ADDR_DEAD_TIME:
          rdata_o <= {2'h0, dead_time_r};
        `ADDR_ALTERNATE_DEAD_TIME:
          rdata_o <= {2'h0, alternate_dead_time_r};
        `ADDR_GENERATOR_CONTROL:
          rdata_o <= {6'h00, time_base_select_r, 1'b0,
                      dead_time_control_r, 5'h00, immediate_update_r};
        `ADDR_OUTPUT_PIN_CONTROL:
          rdata_o <= {4'h0, pin_mode_r, 10'h000};
        `ADDR_MASTER_PERIOD:
          rdata_o <= master_period_r;
        `ADDR_STATUS:
          rdata_o <= {14'h0000, low_side_out_o, high_side_out_o};
        default:
          rdata_o <= 16'h0000;
      endcase
    end
  end

endmodule // pwm_duty_phase_deadtime_regs

// ==== pwm_timing_defines.vh ====
// Register offsets, field positions, reset values and timing counts
// for one PWM generator's duty, phase and dead-time registers.
// Assumes inclusion by bare name from the design files.
`ifndef PWM_TIMING_DEFINES_VH
`define PWM_TIMING_DEFINES_VH

// ****************************************************************
// Register word addresses
// ****************************************************************
`define ADDR_PRIMARY_DUTY         4'h0
`define ADDR_SECONDARY_DUTY       4'h1
`define ADDR_PRIMARY_PHASE        4'h2
`define ADDR_SECONDARY_PHASE      4'h3
`define ADDR_DEAD_TIME            4'h4
`define ADDR_ALTERNATE_DEAD_TIME  4'h5
`define ADDR_GENERATOR_CONTROL    4'h6
`define ADDR_OUTPUT_PIN_CONTROL   4'h7
`define ADDR_MASTER_PERIOD        4'h8
`define ADDR_STATUS               4'h9

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_IMMEDIATE_UPDATE_BIT  0
`define CTL_DTC_LSB               6
`define CTL_TIME_BASE_SELECT_BIT  9
`define PIN_MODE_LSB              10
`define DT_WIDTH                  14

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define RST_ZERO16                16'h0000
`define RST_MASTER_PERIOD         16'hfff8
`define PIN_MODE_COMPLEMENTARY    2'h0
`define PIN_MODE_REDUNDANT        2'h1
`define PIN_MODE_PUSH_PULL        2'h2
`define PIN_MODE_INDEPENDENT      2'h3
`define DTC_POSITIVE              2'h0
`define DTC_NEGATIVE              2'h1
`define DTC_DISABLED              2'h2
`define DUTY_MIN                  16'h0008
`define DUTY_MAX                  16'hffef
`define PERIOD_MARGIN             16'h0008

// ****************************************************************
// Timing
// ****************************************************************
`define EDGE_ZONE_NS              40
`define CLK_PERIOD_NS             40
`define EDGE_ZONE_CYCLES          (`EDGE_ZONE_NS / `CLK_PERIOD_NS)

`endif

// ==== pwm_time_base.v ====
// Free-running period counter for one time base.
// Assumes period_i is held stable by the caller between wraps.
`timescale 1ns/10ps
`include "pwm_timing_defines.vh"

module pwm_time_base #(
  parameter WIDTH = 16
) (
  input  wire             core_clk_i,
  input  wire             rst_i,
  input  wire             clk_en_i,
  input  wire [WIDTH-1:0] period_i,
  output reg  [WIDTH-1:0] count_o,
  output wire             wrap_o
);

  // Wrap at the last count so the period is period_i + 1 ticks
  assign wrap_o = (count_o >= period_i);

  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      count_o <= {WIDTH{1'b0}};
    else if (clk_en_i)
    begin
      if (wrap_o)
        count_o <= {WIDTH{1'b0}};
      else
        count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // pwm_time_base

// ==== pwm_regs_props.sv ====
// Checker for the duty, phase and dead-time register block.
// Assumes it sees only the top ports; bound at the foot of the file.
`timescale 1ns/10ps

module pwm_regs_props (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] rdata_o,
  input  wire logic        high_side_out_o,
  input  wire logic        low_side_out_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  wire rd_t = rd_i & clk_en_i;
  wire wr_t = wr_i & clk_en_i;

  // Write then read of the same word on the next cycle
  sequence wr_rd_s(logic [3:0] lo, logic [3:0] hi);
    wr_t && addr_i >= lo && addr_i <= hi ##1 rd_t && $stable(addr_i);
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) rst_i |-> // RESET
    !high_side_out_o && !low_side_out_o && rdata_o == 16'h0000)
    else $error("outputs not quiet in reset");
  duty_readback_a: assert property (wr_rd_s(4'h0, 4'h3) |=>
    rdata_o == $past(wdata_i, 2))
    else $error("duty or phase readback differs");
  dt_readback_a: assert property (wr_rd_s(4'h4, 4'h5) |=>
    rdata_o == {2'b00, $past(wdata_i[13:0], 2)})
    else $error("dead time readback differs");
  dt_upper_a: assert property (rd_t && addr_i == 4'h4 |=>
    rdata_o[15:14] == 2'b00)
    else $error("dead time upper bits set");
  altdt_upper_a: assert property (rd_t && addr_i == 4'h5 |=>
    rdata_o[15:14] == 2'b00)
    else $error("alternate dead time upper bits set");
  unmapped_zero_a: assert property (rd_t && addr_i >= 4'ha |=> // REFUSED
    rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_t |=> $stable(rdata_o)) // STANDS
    else $error("read data changed without read");
  freeze_all_a: assert property (!clk_en_i |=> $stable(rdata_o) && // PORTS
    $stable(high_side_out_o) && $stable(low_side_out_o))
    else $error("state moved with clock enable low");
endmodule // pwm_regs_props

bind pwm_duty_phase_deadtime_regs pwm_regs_props pwm_regs_props_inst (
  .core_clk_i      (core_clk_i),
  .rst_i           (rst_i),
  .clk_en_i        (clk_en_i),
  .addr_i          (addr_i),
  .wdata_i         (wdata_i),
  .wr_i            (wr_i),
  .rd_i            (rd_i),
  .rdata_o         (rdata_o),
  .high_side_out_o (high_side_out_o),
  .low_side_out_o  (low_side_out_o)
);

// ==== pwm_stage_model.sv ====
// Power stage seen from the gate drivers: measures each pulse width.
// Assumes the outputs are registered on core_clk_i.
`timescale 1ns/10ps

module pwm_stage_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        high_i,
  input  wire logic        low_i,
  output logic             hi_done_o,
  output logic [15:0]      hi_width_o,
  output logic             lo_done_o,
  output logic [15:0]      lo_width_o
);
  // ****************************************************************
  // Pulse counters
  // ****************************************************************
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;

  // Width reported one cycle after the falling edge of each pulse
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hi_cnt_r <= 16'h0000;
      lo_cnt_r <= 16'h0000;
      hi_done_o <= 1'b0;
      lo_done_o <= 1'b0;
      hi_width_o <= 16'h0000;
      lo_width_o <= 16'h0000;
    end
    else
    begin
      hi_done_o <= !high_i && hi_cnt_r != 16'h0000;
      lo_done_o <= !low_i && lo_cnt_r != 16'h0000;
      if (!high_i && hi_cnt_r != 16'h0000)
        hi_width_o <= hi_cnt_r;
      if (!low_i && lo_cnt_r != 16'h0000)
        lo_width_o <= lo_cnt_r;
      hi_cnt_r <= high_i ? hi_cnt_r + 16'h0001 : 16'h0000;
      lo_cnt_r <= low_i ? lo_cnt_r + 16'h0001 : 16'h0000;
    end
  end
endmodule // pwm_stage_model

// ==== tb.sv ====
// Self-checking bench for the duty, phase and dead-time registers.
// Assumes the register map and encodings of the design's defines.
`timescale 1ns/10ps

`define CHK(nm, ex, got) \
  begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic        high_side_out_o;
  logic        low_side_out_o;
  logic        hi_done;
  logic        lo_done;
  logic [15:0] hi_width;
  logic [15:0] lo_width;
  logic [15:0] rq[$];
  logic [15:0] hq[$];
  logic [15:0] lq[$];
  logic [15:0] e_r;
  logic [15:0] d;
  logic        rd_d = 1'b0;
  int          n_tests = 0;
  int          n_errors = 0;

  always #20 core_clk_i = ~core_clk_i;

  pwm_duty_phase_deadtime_regs pwm_duty_phase_deadtime_regs_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .high_side_out_o(high_side_out_o),
    .low_side_out_o(low_side_out_o));

  pwm_stage_model pwm_stage_model_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .high_i(high_side_out_o),
    .low_i(low_side_out_o), .hi_done_o(hi_done), .hi_width_o(hi_width),
    .lo_done_o(lo_done), .lo_width_o(lo_width));

  // ****************************************************************
  // Monitor: oldest note against each result as it appears
  // ****************************************************************
  always @(posedge core_clk_i)
  begin
    rd_d <= rd_i & clk_en_i;
    if (rd_d && rq.size() > 0)
    begin
      e_r = rq.pop_front();
      `CHK("rdata", e_r, rdata_o)
    end
    if (hi_done && hq.size() > 0)
    begin
      e_r = hq.pop_front();
      `CHK("high width", e_r, hi_width)
    end
    if (lo_done && lq.size() > 0)
    begin
      e_r = lq.pop_front();
      `CHK("low width", e_r, lo_width)
    end
  end

  // ****************************************************************
  // Tasks; strobes stay up between back-to-back accesses
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] ex);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    rq.push_back(ex);
    @(posedge core_clk_i);
  endtask

  task automatic idle();
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // Lets old settings wash out, then notes the next pulse widths
  task automatic pulses(input logic [15:0] h, input logic [15:0] l);
    int k = 0;
    repeat (3000)
    begin
      @(posedge core_clk_i);
      if (hi_done === 1'b1)
        k++;
      if (k == 3)
        break;
    end
    hq.push_back(h);
    lq.push_back(l);
    repeat (3000)
    begin
      if (hq.size() == 0 && lq.size() == 0)
        break;
      @(posedge core_clk_i);
    end
    if (k != 3 || hq.size() != 0 || lq.size() != 0)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic conclude();
    if (rq.size() != 0)
      n_errors++;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    // Nonblocking, so the asynchronous reset edge is seen at time zero
    rst_i <= 1'b1;
    void'($urandom(32'h4fa6dd3d));
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    for (int a = 0; a < 6; a++)
      rd(4'(a), 16'h0000);
    rd(4'h8, 16'hfff8);
    for (int a = 0; a < 6; a++)
    begin
      d = 16'($urandom);
      wr(4'(a), d);
      rd(4'(a), a > 3 ? d & 16'h3fff : d);
    end
    for (int a = 10; a < 16; a++)
    begin
      wr(4'(a), 16'($urandom));
      rd(4'(a), 16'h0000);
    end
    // Clock enable low must swallow the strobe
    wr(4'h0, 16'h1234);
    clk_en_i <= 1'b0;
    wr(4'h0, 16'h5678);
    clk_en_i <= 1'b1;
    rd(4'h0, 16'h1234);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0000);
    wr(4'h8, 16'h0040);
    wr(4'h6, 16'h0080);
    wr(4'h0, 16'h0010);
    wr(4'h1, 16'h0020);
    wr(4'h2, 16'h0005);
    wr(4'h7, 16'h0400);
    rd(4'h7, 16'h0400);
    idle();
    pulses(16'h0010, 16'h0010);
    wr(4'h7, 16'h0c00);
    idle();
    pulses(16'h0010, 16'h0020);
    wr(4'h7, 16'h0400);
    wr(4'h0, 16'h0002);
    idle();
    pulses(16'h0008, 16'h0008);
    // Complementary: positive dead time trims, negative widens
    wr(4'h4, 16'h0003);
    wr(4'h5, 16'h0005);
    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h0000);
    wr(4'h0, 16'h0010);
    rd(4'h7, 16'h0000);
    idle();
    pulses(16'h000d, 16'h002c);
    wr(4'h6, 16'h0040);
    idle();
    pulses(16'h0015, 16'h0034);
    // Push-pull with immediate update, zero phase keeps pulses whole
    wr(4'h2, 16'h0000);
    wr(4'h6, 16'h0081);
    wr(4'h7, 16'h0800);
    rd(4'h6, 16'h0081);
    idle();
    pulses(16'h0010, 16'h0010);
    wr(4'h7, 16'h0400);
    wr(4'h6, 16'h0280);
    wr(4'h2, 16'h0020);
    wr(4'h3, 16'h0100);
    wr(4'h0, 16'h0030);
    idle();
    pulses(16'h0018, 16'h0018);
    idle();
    conclude();
  end
endmodule // tb
